/* File: verilog/hsr_slave.sv */
`timescale 1ns/1ps
`default_nettype none

`include "hsr_cfg.svh"

module hsr_slave (
  input  wire logic            clk_sys,          // system clock, 10 MHz
  input  wire logic            nrst,             // async reset, active low
  input  wire logic            clk_link,         // link sampling clock
  input  wire logic            scl_i,            // serial clock pin level
  input  wire logic            sda_i,            // serial data pin level
  output logic                 sda_o,            // serial data drive value
  output logic                 sda_oe_n,         // low while we pull sda
  input  wire logic [23:0]     status_in,        // status bytes for 00..02
  input  wire logic            low_power_req,    // request low power state
  output logic                 low_power_state,  // low power state reached
  output logic                 wr_valid,         // register write offered
  input  wire logic            wr_ready,         // consumer takes the write
  output hsr_pkg::hsr_wr_t     wr                // register write, buffered
);
  import hsr_pkg::*;

  // ----------------------------------------------------------------------
  // read lookup
  // ----------------------------------------------------------------------
  // status bytes, then stored bytes, then FF for anything not mapped
  function automatic logic [7:0] hsr_read_byte(
    input logic [7:0]       addr,
    input logic [23:0]      status,
    input logic [15:0][7:0] regs
  );
    if (addr < 8'(`HSR_STATUS_COUNT))
      return status[addr[1:0]*8 +: 8];
    else if (addr < 8'(`HSR_REG_COUNT))
      return regs[addr[3:0]];
    return `HSR_UNMAPPED_BYTE;
  endfunction : hsr_read_byte

  // writable when mapped and not a status byte
  function automatic logic hsr_writable(input logic [7:0] addr);
    return (addr >= 8'(`HSR_STATUS_COUNT)) && (addr < 8'(`HSR_REG_COUNT));
  endfunction : hsr_writable

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  hsr_link_state_t l;         // link domain state
  hsr_link_state_t next_l;    // link domain next state
  hsr_sys_state_t  s;         // system domain state
  hsr_sys_state_t  next_s;    // system domain next state
  logic            buf_ready; // write buffer has room
  logic            buf_push;  // write offered to the buffer
  hsr_wr_t         buf_in;    // write offered to the buffer

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // open drain: only ever drive low, enable active low; scl has no driver
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~l.drive_low;

  // ----------------------------------------------------------------------
  // link domain protocol engine
  // ----------------------------------------------------------------------
  // sampled on a fast free clock so both bus rates look alike
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    next_l   = l;
    // synchronisers: first stage feeds only the second
    next_l.scl1 = scl_i;
    next_l.scl2 = l.scl1;
    next_l.scl3 = l.scl2;
    next_l.sda1 = sda_i;
    next_l.sda2 = l.sda1;
    next_l.sda3 = l.sda2;
    next_l.lp1  = s.lp_state;
    next_l.lp2  = l.lp1;
    next_l.ack1 = s.ack_tog;
    next_l.ack2 = l.ack1;
    scl_rise = l.scl2 && !l.scl3;
    scl_fall = !l.scl2 && l.scl3;
    start    = l.scl2 && l.scl3 && l.sda3 && !l.sda2;
    stop     = l.scl2 && l.scl3 && !l.sda3 && l.sda2;
    // answer from the system domain retires the pending request
    if (l.ack2 != l.ack_seen)
    begin
      next_l.ack_seen = l.ack2;
      next_l.pending  = 1'b0;
      if (!l.req.is_write)
        next_l.rbuf = s.rdata;  // stable since the toggle crossed
    end
    if (stop)
    begin
      next_l.st        = HSR_IDLE;
      next_l.drive_low = 1'b0;
    end
    else if (start)
    begin
      if (l.lp2)
      begin
        next_l.st        = HSR_IDLE;
        next_l.drive_low = 1'b0;
      end
      else
      begin
        next_l.st        = HSR_ADDR;
        next_l.cnt       = '0;
        next_l.drive_low = 1'b0;
      end
    end
    else
    begin
      case (l.st)
        HSR_IDLE:
        begin
          next_l.drive_low = 1'b0;
        end
        HSR_ADDR, HSR_RX:
        begin
          // sample on the rising edge, data is stable while scl high
          if (scl_rise && l.cnt < `HSR_FRAME_BITS)
          begin
            next_l.sh  = {l.sh[6:0], l.sda2};
            next_l.cnt = l.cnt + 4'h1;
          end
          else if (scl_fall && l.cnt == `HSR_FRAME_BITS)
          begin
            next_l.cnt = '0;
            if (l.st == HSR_ADDR)
            begin
              if (l.sh[7:1] == `HSR_DEV_ADDR)
              begin
                next_l.st        = HSR_ACK;
                next_l.ack_bit   = 1'b1;
                next_l.drive_low = 1'b1;
                next_l.rw        = l.sh[0];
                next_l.first     = 1'b1;
                // fetch the first read byte during the ack bit
                if (l.sh[0] && !l.pending)
                begin
                  next_l.req     = '{is_write: 1'b0, addr: l.ptr, data: 8'h00};
                  next_l.req_tog = ~l.req_tog;
                  next_l.pending = 1'b1;
                end
              end
              else
                next_l.st = HSR_IDLE;          // silent
            end
            else if (l.first)
            begin
              next_l.ptr       = l.sh;
              next_l.first     = 1'b0;
              next_l.st        = HSR_ACK;
              next_l.ack_bit   = 1'b1;
              next_l.drive_low = 1'b1;
            end
            else
            begin
              // a full buffer leaves the last request pending: refuse
              next_l.st        = HSR_ACK;
              next_l.ack_bit   = !l.pending;
              next_l.drive_low = !l.pending;
              if (!l.pending)
              begin
                next_l.req     = '{is_write: 1'b1, addr: l.ptr, data: l.sh};
                next_l.req_tog = ~l.req_tog;
                next_l.pending = 1'b1;
                next_l.ptr     = l.ptr + 8'h01;
              end
            end
          end
        end
        HSR_ACK:
        begin
          // release only after scl falls so sda never moves while high
          if (scl_fall)
          begin
            next_l.drive_low = 1'b0;
            next_l.ack_bit   = 1'b0;
            if (l.rw)
            begin
              next_l.st        = HSR_TX;
              next_l.sh        = {l.rbuf[6:0], 1'b0};
              next_l.drive_low = !l.rbuf[7];
              next_l.ptr       = l.ptr + 8'h01;
              // prefetch the following byte well ahead of its frame
              next_l.req     = '{is_write: 1'b0, addr: l.ptr + 8'h01, data: 8'h00};
              next_l.req_tog = ~l.req_tog;
              next_l.pending = 1'b1;
            end
            else
              next_l.st = HSR_RX;
          end
        end
        HSR_TX:
        begin
          if (scl_rise)
            next_l.cnt = l.cnt + 4'h1;
          else if (scl_fall)
          begin
            if (l.cnt == `HSR_FRAME_BITS)
            begin
              next_l.drive_low = 1'b0;     // master drives its ack
              next_l.st        = HSR_MACK;
              next_l.acked     = 1'b0;
            end
            else
            begin
              next_l.drive_low = !l.sh[7];
              next_l.sh        = {l.sh[6:0], 1'b0};
            end
          end
        end
        HSR_MACK:
        begin
          if (scl_rise)
          begin
            next_l.acked = !l.sda2;
            next_l.cnt   = '0;
          end
          else if (scl_fall)
          begin
            if (l.acked && !l.pending)
            begin
              next_l.st        = HSR_TX;
              next_l.sh        = {l.rbuf[6:0], 1'b0};
              next_l.drive_low = !l.rbuf[7];
              next_l.ptr       = l.ptr + 8'h01;
              next_l.req     = '{is_write: 1'b0, addr: l.ptr + 8'h01, data: 8'h00};
              next_l.req_tog = ~l.req_tog;
              next_l.pending = 1'b1;
            end
            else
              next_l.st = HSR_IDLE;  // not acknowledged, or next byte still pending: end of read
          end
        end
        default:
        begin
          next_l.st        = HSR_IDLE;
          next_l.drive_low = 1'b0;
        end
      endcase
    end
    next_l.busy = (next_l.st != HSR_IDLE) || next_l.pending;  // one flop, no decode glitch
  end

  // idle pins are high after reset, so the sampled levels start high
  always_ff @(posedge clk_link or negedge nrst)
  begin
    if (!nrst)
    begin
      l      <= '0;
      l.scl1 <= 1'b1;
      l.scl2 <= 1'b1;
      l.scl3 <= 1'b1;
      l.sda1 <= 1'b1;
      l.sda2 <= 1'b1;
      l.sda3 <= 1'b1;
      l.st   <= HSR_IDLE;
    end
    else
      l <= next_l;
  end

  // ----------------------------------------------------------------------
  // system domain register file
  // ----------------------------------------------------------------------
  // requests arrive as a toggle; payload was frozen before it toggled
  always_comb
  begin
    logic new_req;
    new_req     = 1'b0;
    next_s      = s;
    buf_push    = 1'b0;
    buf_in      = '{addr: l.req.addr, data: l.req.data};
    next_s.req1 = l.req_tog;
    next_s.req2 = s.req1;
    next_s.busy1 = l.busy;
    next_s.busy2 = s.busy1;
    new_req = (s.req2 != s.req3);
    if (new_req)
    begin
      if (!l.req.is_write)
      begin
        next_s.rdata   = hsr_read_byte(l.req.addr, status_in, s.regs);
        next_s.ack_tog = ~s.ack_tog;
        next_s.req3    = s.req2;
      end
      else if (!hsr_writable(l.req.addr))
      begin
        next_s.ack_tog = ~s.ack_tog;  // dropped, no effect
        next_s.req3    = s.req2;
      end
      else if (buf_ready)
      begin
        buf_push       = 1'b1;
        next_s.ack_tog = ~s.ack_tog;
        next_s.req3    = s.req2;
      end
      // buffer full: leave the request unanswered until room appears
    end
    // stored value follows the write the consumer accepts
    if (wr_valid && wr_ready)
      next_s.regs[wr.addr[3:0]] = wr.data;
    // enter only once the port is idle, leave as soon as asked
    if (!low_power_req)
      next_s.lp_state = 1'b0;
    else if (!s.busy2 && !new_req)
      next_s.lp_state = 1'b1;
  end

  // storage clears only on reset, i.e. when both supplies have dropped
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign low_power_state = s.lp_state;

  // ----------------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------------
  // a stalled consumer fills it; the link then acknowledges one more byte, holds it pending and refuses the rest
  hsr_buf2 #(
    .W     ($bits(hsr_wr_t)),
    .DEPTH (`HSR_BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (buf_push),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr)
  );

endmodule : hsr_slave

`default_nettype wire

/* File: verilog/hsr_cfg.svh */
`ifndef HSR_CFG_SVH
`define HSR_CFG_SVH

// ----------------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------------
`define HSR_DEV_ADDR      7'h6B   // own 7-bit slave address (write byte D6)
`define HSR_UNMAPPED_BYTE 8'hFF   // read answer outside the register map

// ----------------------------------------------------------------------
// register map layout
// ----------------------------------------------------------------------
`define HSR_REG_COUNT     16      // implemented byte registers 00..0F
`define HSR_STATUS_COUNT  3       // 00..02 read the status inputs
`define HSR_REG_RESET     8'h00   // reset value of writable registers

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define HSR_FRAME_BITS    4'h8    // data bits before the acknowledge bit
`define HSR_BUF_DEPTH     2       // entries in the write buffer

`endif

/* File: verilog/hsr_pkg.sv */
`default_nettype none

package hsr_pkg;

  // link-side protocol states
  typedef enum logic [2:0] {
    HSR_IDLE,   // waiting for a start
    HSR_ADDR,   // shifting in the address byte
    HSR_RX,     // shifting in a written byte
    HSR_ACK,    // acknowledge bit driven (or withheld) by us
    HSR_TX,     // shifting out a read byte
    HSR_MACK    // acknowledge bit from the master
  } hsr_link_st_t;

  // one register write as it leaves the block
  typedef struct packed {
    logic [7:0] addr;   // register index
    logic [7:0] data;   // byte written
  } hsr_wr_t;

  // request carried from the link domain to the system domain
  typedef struct packed {
    logic       is_write;  // 1 write, 0 read
    logic [7:0] addr;      // register index
    logic [7:0] data;      // write data
  } hsr_req_t;

  // all state of the link domain
  typedef struct packed {
    logic         scl1, scl2, scl3;  // scl synchroniser and previous value
    logic         sda1, sda2, sda3;  // sda synchroniser and previous value
    logic         lp1, lp2;          // low power level from system domain
    logic         ack1, ack2;        // answer toggle from system domain
    hsr_link_st_t st;                // protocol state
    logic [3:0]   cnt;               // bits of the current frame
    logic [7:0]   sh;                // shift register
    logic [7:0]   ptr;               // register pointer
    logic         rw;                // direction of this transfer
    logic         first;             // next written byte is the pointer
    logic         acked;             // master acknowledged the last byte
    logic         ack_bit;           // we pull sda low in this ack bit
    logic         drive_low;         // sda pulled low
    logic         req_tog;           // request toggle
    hsr_req_t     req;               // request payload, held while pending
    logic         pending;           // request not yet answered
    logic         ack_seen;          // last answer toggle consumed
    logic [7:0]   rbuf;              // prefetched read byte
    logic         busy;              // engaged, registered before crossing
  } hsr_link_state_t;

  // all state of the system domain
  typedef struct packed {
    logic                   req1, req2, req3;  // request toggle sync, seen
    logic                   busy1, busy2;      // link busy level sync
    logic                   ack_tog;           // answer toggle
    logic [7:0]             rdata;             // read answer
    logic                   lp_state;          // low power state
    logic [15:0][7:0]       regs;              // register storage
  } hsr_sys_state_t;

endpackage : hsr_pkg

`default_nettype wire

/* File: verilog/hsr_buf2.sv */
`timescale 1ns/1ps
`default_nettype none

// two-entry valid/ready buffer; full back-pressures the writer
module hsr_buf2 #(
  parameter int W     = 16,  // word width
  parameter int DEPTH = 2    // entries, a power of two
) (
  input  wire logic         clk_sys,   // system clock
  input  wire logic         nrst,      // async reset, active low
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // word available
  input  wire logic         out_ready, // consumer takes the word
  output logic [W-1:0]      out_data   // word out, from flip-flops
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;   // storage
    logic [AW-1:0]           wp;    // write pointer
    logic [AW-1:0]           rp;    // read pointer
    logic [AW:0]             count; // words held
  } hsr_buf_state_t;

  hsr_buf_state_t s;       // registered state
  hsr_buf_state_t next_s;  // next state

  assign in_ready  = (s.count != (AW+1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rp];

  // push and pop may happen in the same cycle
  always_comb
  begin
    logic push;
    logic pop;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = s.wp + 1'b1;
    end
    if (pop)
      next_s.rp = s.rp + 1'b1;
    if (push && !pop)
      next_s.count = s.count + 1'b1;
    else if (pop && !push)
      next_s.count = s.count - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : hsr_buf2

`default_nettype wire

/* File: verification/hsr_slave_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// port checker for the serial slave
// ----------------------------------------------------------------
module hsr_slave_assertions (
  input wire logic             clk_sys,          // system clock
  input wire logic             nrst,             // async reset, active low
  input wire logic             clk_link,         // link sampling clock
  input wire logic             scl_i,            // bus clock level
  input wire logic             sda_i,            // bus data level
  input wire logic             sda_o,            // data drive value
  input wire logic             sda_oe_n,         // low while we pull sda
  input wire logic             low_power_req,    // low power request
  input wire logic             low_power_state,  // port disabled
  input wire logic             wr_valid,         // write offered
  input wire logic             wr_ready,         // write taken
  input wire hsr_pkg::hsr_wr_t wr                // buffered write
);
  import hsr_pkg::*;

  // bus conditions: data edge while the clock stays high
  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence

  a_hold_scl_high: assert property (@(posedge clk_link) disable iff (!nrst)
    scl_i && $past(scl_i) |-> $stable(sda_oe_n)) else $error("sda drive moved, scl high");
  a_move_scl_low: assert property (@(posedge clk_link) disable iff (!nrst)
    $changed(sda_oe_n) |-> !scl_i) else $error("sda drive moved outside scl low");
  a_open_drain: assert property (@(posedge clk_link) disable iff (!nrst)
    !sda_oe_n |-> sda_o == 1'b0) else $error("sda driven high");
  a_start_quiet: assert property (@(posedge clk_link) disable iff (!nrst)
    s_start |=> sda_oe_n [*8]) else $error("sda pulled right after start");
  a_stop_quiet: assert property (@(posedge clk_link) disable iff (!nrst)
    s_stop |=> sda_oe_n [*8]) else $error("sda pulled right after stop");
  a_ack_held: assert property (@(posedge clk_link) disable iff (!nrst)
    $fell(sda_oe_n) |=> !sda_oe_n [*4]) else $error("sda pull too short");
  a_lp_silent: assert property (@(posedge clk_sys) disable iff (!nrst)
    low_power_state |-> sda_oe_n) else $error("sda pulled in low power");
  a_lp_entry: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(low_power_state) |-> $past(low_power_req)) else $error("low power unasked");
  a_lp_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
    !low_power_req |=> !low_power_state) else $error("low power not left");
  a_wr_stall: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_valid && !wr_ready |=> wr_valid && $stable(wr)) else $error("stalled write lost");
endmodule : hsr_slave_assertions

bind hsr_slave hsr_slave_assertions u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .low_power_req(low_power_req),
  .low_power_state(low_power_state), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr)
);

`default_nettype wire

/* File: verification/hsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bus master model: owns the clock, pulls lines only low
// ----------------------------------------------------------------
module hsr_host_model (
  input  wire logic clk_sys,  // pacing clock
  input  wire logic sda_i,    // resolved data line
  output var logic  scl_low,  // pulls scl low
  output var logic  sda_low   // pulls sda low
);
  int q = 7;  // quarter bit in clk_sys cycles, about 357 kbps

  initial scl_low = 1'b0;  // released: the pull-up holds it high
  initial sda_low = 1'b0;

  // moves land just after a falling edge, away from the sampling edge
  task automatic wt();
    repeat (q) @(negedge clk_sys);
  endtask : wt

  // start or repeated start, entered with scl low or idle
  task automatic start();
    sda_low = 1'b0;
    wt();
    scl_low = 1'b0;
    wt();
    sda_low = 1'b1;
    wt();
    scl_low = 1'b1;
    wt();
  endtask : start

  // stop, also used to end an abandoned transfer
  task automatic stop();
    sda_low = 1'b1;
    wt();
    scl_low = 1'b0;
    wt();
    sda_low = 1'b0;
    wt();
  endtask : stop

  // one bit: data set while scl low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    wt();
    scl_low = 1'b0;
    wt();
    r = sda_i;
    wt();
    scl_low = 1'b1;
    wt();
  endtask : bit_x

  // frame: eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(mack, ack);
  endtask : xfer
endmodule : hsr_host_model

`default_nettype wire

/* File: verification/test_hsr_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module test_hsr_slave;
  import hsr_pkg::*;

  // ----------------------------------------------------------------
  // clocks, pins and the resolved bus wires
  // ----------------------------------------------------------------
  logic        clk_sys       = 1'b0;          // 10 MHz
  logic        clk_link      = 1'b0;          // 15 ns, own phase
  logic        nrst          = 1'b0;          // reset, active low
  logic        wr_ready      = 1'b0;          // consumer stalls at first
  logic        low_power_req = 1'b0;          // low power request
  logic [23:0] status_in     = 24'hC35A81;    // status bytes 00..02
  logic        sda_o, sda_oe_n, low_power_state, wr_valid, scl_low, sda_low;
  hsr_wr_t     wr;                            // buffered write
  wire logic   scl_line = ~scl_low;           // pull-up unless pulled
  wire logic   sda_line = ~sda_low & (sda_oe_n | sda_o);  // wired-and
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  hsr_slave uut (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl_line),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .status_in(status_in),
    .low_power_req(low_power_req), .low_power_state(low_power_state),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));
  hsr_host_model h (.clk_sys(clk_sys), .sda_i(sda_line), .scl_low(scl_low), .sda_low(sda_low));

  always #50 clk_sys = ~clk_sys;
  initial
  begin
    #3;
    forever #7.5 clk_link = ~clk_link;
  end

  // hang guard: the whole run needs roughly 13000 cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // comparison, verdict and byte helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // master sends a byte; e is the line level expected in the ack bit
  task automatic snd(input logic [7:0] d, input logic e);
    logic [7:0] r;
    logic       a;
    h.xfer(d, 1'b1, r, a);
    chk("ack", {15'h0, a}, {15'h0, e});
  endtask : snd

  // master reads a byte and answers ack (0) or nack (1)
  task automatic rcv(input logic [7:0] e, input logic mack);
    logic [7:0] r;
    logic       a;
    h.xfer(8'hFF, mack, r, a);
    chk("rdata", {8'h0, r}, {8'h0, e});
  endtask : rcv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // foreign address ignored, then our address abandoned by a stop
  task automatic t_foreign();
    h.start();
    snd(8'hD4, 1'b1);
    snd(8'h07, 1'b1);
    h.stop();
    h.start();
    snd(8'hD6, 1'b0);
    h.stop();
    repeat (20) @(negedge clk_sys);
    chk("wr_valid", {15'h0, wr_valid}, 16'h0000);
  endtask : t_foreign

  // pointer then four data bytes: three held while the consumer stalls, the fourth refused
  task automatic t_write();
    h.start();
    snd(8'hD6, 1'b0);
    snd(8'h05, 1'b0);
    snd(8'hA5, 1'b0);
    snd(8'h3C, 1'b0);
    snd(8'h77, 1'b0);
    snd(8'h88, 1'b1);
    h.stop();
    repeat (20) @(negedge clk_sys);
    chk("wr_valid", {15'h0, wr_valid}, 16'h0001);
    chk("wr0", wr, 16'h05A5);
    wr_ready = 1'b1;
    @(negedge clk_sys);
    chk("wr1", wr, 16'h063C);
    @(negedge clk_sys);
    chk("wr2", wr, 16'h0777);
    @(negedge clk_sys);
    chk("wr_drained", {15'h0, wr_valid}, 16'h0000);
    wr_ready = 1'b0;
  endtask : t_write

  // set pointer, repeated start, read two bytes
  task automatic t_read(input logic [7:0] p, e0, e1);
    h.start();
    snd(8'hD6, 1'b0);
    snd(p, 1'b0);
    h.start();
    snd(8'hD7, 1'b0);
    rcv(e0, 1'b0);
    rcv(e1, 1'b1);
    h.stop();
  endtask : t_read

  // low power: port silent, then low_power_state drops once the request is released
  task automatic t_lp();
    low_power_req = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("lp_on", {15'h0, low_power_state}, 16'h0001);
    h.start();
    snd(8'hD6, 1'b1);
    h.stop();
    low_power_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("lp_off", {15'h0, low_power_state}, 16'h0000);
  endtask : t_lp

  initial
  begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_foreign();
    t_write();
    t_read(8'h05, 8'hA5, 8'h3C);
    t_read(8'h01, status_in[15:8], status_in[23:16]);
    t_read(8'h0F, 8'h00, 8'hFF);
    t_read(8'hFF, 8'hFF, status_in[7:0]);
    t_lp();
    h.q = 25;  // 100 kbps
    t_read(8'h10, 8'hFF, 8'hFF);
    wrap_up();
  end
endmodule : test_hsr_slave

`default_nettype wire
